// ==== logic/ccsr_pkg.sv ====
// Purpose: Shared constants and types for the CAN channel signal routing block
// Assumes: Six controller channels, AXI4-Lite register access with 32-bit data
// Notes: Bus level 0 is dominant, 1 is recessive
package ccsr_pkg;
  localparam int CCSR_CHANNELS = 6;
  localparam int CCSR_CAPTURE_INPUTS = 16;
  // Second capture input of channel n sits this many inputs above the first
  localparam int CCSR_CAPTURE_SECOND = 10;
  localparam logic [31:0] CCSR_ROUTE_ADDR = 32'hff772008;
  localparam logic [31:0] CCSR_STATUS_ADDR = 32'hff77200c;
  localparam logic [31:0] CCSR_MASK_ADDR = 32'hff772010;
  localparam logic [7:0] CCSR_ROUTE_RESET = 8'h00;
  localparam int CCSR_ROUTE_SHARED_BIT = 0;
  localparam logic [7:0] CCSR_STATUS_RESET = 8'h00;
  localparam logic [7:0] CCSR_MASK_RESET = 8'h00;
  // Status and mask layout: bits 5..0 channel wake, bit 6 stand-by wake request (request or bus activity)
  localparam int CCSR_EV_BUS_WAKE = 6;
  localparam int CCSR_EV_WIDTH = 7;
  localparam logic CCSR_RECESSIVE = 1'b1;
  localparam logic [1:0] CCSR_RESP_OKAY = 2'b00;
  localparam logic [1:0] CCSR_RESP_DECERR = 2'b11;

  // Request group of one controller channel
  typedef struct packed {
    logic error;
    logic rx_done;
    logic tx_done;
    logic wake_abort;
  } ccsr_req_type;

  typedef struct packed {
    logic rx;
    logic tx;
  } ccsr_bus_type;

  typedef enum logic [1:0] {
    CCSR_WR_IDLE = 2'b00,
    CCSR_WR_RESP = 2'b01
  } ccsr_wr_state_type;
endpackage

// ==== logic/ccsr_top.sv ====
// Purpose: Interrupt, DMA, wake, reset, time stamp and bus pin routing around six CAN controllers
// Assumes: Controller side signals run on clk_sys; bus receive pins are asynchronous
// Notes: Registers reached over AXI4-Lite; one write and one read under way at a time
// Functional notes
// RQ1: Channel 5 transmit-done drives its interrupt line and DMA trigger 33.
// RQ2: Each channel offers error, receive-done, transmit-done and wake/abort request outputs.
// RQ3: Wake requests of all channels are ORed into one combined interrupt.
// RQ4: Controller interrupt requests can end any stand-by mode as wake sources.
// RQ5: Controllers reset on system reset and on deep-stop wake-up reset.
// RQ6: Bus receive and transmit activity can also wake the system from stand-by.
// RQ7: Each time stamp pulse reaches two capture inputs of the timer array.
// RQ8: Selection bit 0 clear: controller 0 uses its own bus pins.
// RQ9: Selection bit set: controller 0 shares controller 1's bus pins.
// RQ10: Selection register is byte accessible, read/write, resets to zero.
// RQ11: In shared mode a dominant level from either controller drives shared transmit.
// RQ12: Software changes selection only while both controllers are initialising.
module ccsr_top
  import ccsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic system_reset_src,
  input wire logic deep_stop_wake_reset,
  input wire logic deep_stop_mode,
  input wire logic standby_mode,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ccsr_pkg::ccsr_req_type [ccsr_pkg::CCSR_CHANNELS-1:0] ctrl_req,
  input wire logic [ccsr_pkg::CCSR_CHANNELS-1:0] ctrl_timestamp,
  input wire logic [ccsr_pkg::CCSR_CHANNELS-1:0] ctrl_bus_tx,
  output logic [ccsr_pkg::CCSR_CHANNELS-1:0] ctrl_bus_rx,
  output logic ctrl_rstn,
  input wire logic [ccsr_pkg::CCSR_CHANNELS-1:0] bus_rx_pin,
  output ccsr_pkg::ccsr_req_type [ccsr_pkg::CCSR_CHANNELS-1:0] irq_req,
  output logic dma_trigger_33,
  output logic combined_wake_irq,
  output logic standby_wake_req,
  output logic [ccsr_pkg::CCSR_CHANNELS-1:0] bus_tx_pin,
  output logic [ccsr_pkg::CCSR_CAPTURE_INPUTS-1:0] timestamp_pulse_out,
  output logic irq
);
  import ccsr_pkg::*;

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [CCSR_CHANNELS-1:0] rx_meta_r;
  logic [CCSR_CHANNELS-1:0] rx_sync_r;
  logic [7:0] route_r;
  logic shared_bus_select_bit;
  logic [CCSR_EV_WIDTH-1:0] status_r;
  logic [CCSR_EV_WIDTH-1:0] status_nxt;
  logic [CCSR_EV_WIDTH-1:0] mask_r;
  logic [CCSR_EV_WIDTH-1:0] events;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  ccsr_wr_state_type wr_state_r;
  logic wr_fire;
  logic [CCSR_CHANNELS-1:0] wake_vec;
  logic any_irq;
  logic bus_active;
  logic [CCSR_CAPTURE_INPUTS-1:0] capture_nxt;

  function automatic logic addr_mapped(input logic [31:0] addr);
    addr_mapped = (addr == CCSR_ROUTE_ADDR) || (addr == CCSR_STATUS_ADDR) || (addr == CCSR_MASK_ADDR);
  endfunction

  // Release of the local reset through two flip-flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Controller reset follows either reset source combinationally so a pulse is never missed
  assign ctrl_rstn = rst_n && !system_reset_src && !deep_stop_wake_reset; // RQ5

  // Receive pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta_r <= {CCSR_CHANNELS{CCSR_RECESSIVE}};
      rx_sync_r <= {CCSR_CHANNELS{CCSR_RECESSIVE}};
    end
    else
    begin
      rx_meta_r <= bus_rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  assign shared_bus_select_bit = route_r[CCSR_ROUTE_SHARED_BIT];

  // Receive routing to the controllers
  always_comb
  begin
    ctrl_bus_rx = rx_sync_r;
    if (shared_bus_select_bit)
      ctrl_bus_rx[0] = rx_sync_r[1]; // RQ9
    else
      ctrl_bus_rx[0] = rx_sync_r[0]; // RQ8
  end

  // Transmit pins are registered; unused pin 0 idles recessive in shared mode
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bus_tx_pin <= {CCSR_CHANNELS{CCSR_RECESSIVE}};
    else
    begin
      bus_tx_pin <= ctrl_bus_tx;
      if (shared_bus_select_bit)
      begin
        bus_tx_pin[0] <= CCSR_RECESSIVE; // RQ9
        bus_tx_pin[1] <= ctrl_bus_tx[0] & ctrl_bus_tx[1]; // RQ11
      end
    end
  end

  // Request outputs toward the interrupt and DMA controllers
  always_comb
  begin
    for (int i = 0; i < CCSR_CHANNELS; i++)
      wake_vec[i] = ctrl_req[i].wake_abort;
  end
  assign any_irq = |ctrl_req;
  // Dominant on any receive pin or driven transmit counts as bus activity
  assign bus_active = !(&rx_sync_r) || !(&ctrl_bus_tx);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_req <= '0;
      dma_trigger_33 <= 1'b0;
      combined_wake_irq <= 1'b0;
      standby_wake_req <= 1'b0;
    end
    else
    begin
      irq_req <= ctrl_req; // RQ2
      dma_trigger_33 <= ctrl_req[5].tx_done; // RQ1
      combined_wake_irq <= |wake_vec; // RQ3
      // Wake only matters while the system sleeps; deep stop counts as stand-by too
      standby_wake_req <= (standby_mode || deep_stop_mode) && (any_irq || bus_active); // RQ4 RQ6
    end
  end

  // Each time stamp reaches capture inputs n and n plus ten
  always_comb
  begin
    capture_nxt = '0;
    for (int i = 0; i < CCSR_CHANNELS; i++)
    begin
      capture_nxt[i] = ctrl_timestamp[i]; // RQ7
      capture_nxt[i + CCSR_CAPTURE_SECOND] = ctrl_timestamp[i]; // RQ7
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      timestamp_pulse_out <= '0;
    else
      timestamp_pulse_out <= capture_nxt;
  end

  // Write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held_r && (wr_state_r == CCSR_WR_IDLE);
  assign s_axi_wready = !w_held_r && (wr_state_r == CCSR_WR_IDLE);
  assign wr_fire = aw_held_r && w_held_r && (wr_state_r == CCSR_WR_IDLE);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_state_r <= CCSR_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CCSR_RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        CCSR_WR_IDLE:
        begin
          if (wr_fire)
          begin
            wr_state_r <= CCSR_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_mapped(awaddr_r) ? CCSR_RESP_OKAY : CCSR_RESP_DECERR;
          end
        end
        CCSR_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state_r <= CCSR_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wr_state_r <= CCSR_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Route selection; deep-stop wake reset clears it like the controllers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      route_r <= CCSR_ROUTE_RESET; // RQ10
    else if (system_reset_src || deep_stop_wake_reset)
      route_r <= CCSR_ROUTE_RESET; // RQ5
    else if (wr_fire && (awaddr_r == CCSR_ROUTE_ADDR) && wstrb_r[0])
      route_r <= wdata_r[7:0]; // RQ10 RQ12
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= CCSR_MASK_RESET[CCSR_EV_WIDTH-1:0];
    else if (wr_fire && (awaddr_r == CCSR_MASK_ADDR) && wstrb_r[0])
      mask_r <= wdata_r[CCSR_EV_WIDTH-1:0];
  end

  // Sticky events, write one to clear; a new event wins over the clear
  assign events = {standby_wake_req, wake_vec};
  always_comb
  begin
    status_nxt = status_r;
    if (wr_fire && (awaddr_r == CCSR_STATUS_ADDR) && wstrb_r[0])
      status_nxt = status_nxt & ~wdata_r[CCSR_EV_WIDTH-1:0];
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_r <= CCSR_STATUS_RESET[CCSR_EV_WIDTH-1:0];
      irq <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
    end
  end

  // Read channel: answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CCSR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? CCSR_RESP_OKAY : CCSR_RESP_DECERR;
      if (s_axi_araddr == CCSR_ROUTE_ADDR)
        s_axi_rdata <= {24'h000000, route_r}; // RQ10
      else if (s_axi_araddr == CCSR_STATUS_ADDR)
        s_axi_rdata <= {25'h0000000, status_r};
      else if (s_axi_araddr == CCSR_MASK_ADDR)
        s_axi_rdata <= {25'h0000000, mask_r};
      else
        s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// ==== sim/ccsr_top_properties.sv ====
// Purpose: Port level checks of ccsr_top
// Assumes: Transmit held recessive while the route bit changes
// Notes: Route bit is internal, so pin checks avoid the mode
module ccsr_top_properties
  import ccsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic system_reset_src,
  input wire logic deep_stop_wake_reset,
  input wire logic standby_mode,
  input wire ccsr_req_type [CCSR_CHANNELS-1:0] ctrl_req,
  input wire logic [CCSR_CHANNELS-1:0] ctrl_timestamp,
  input wire logic [CCSR_CHANNELS-1:0] ctrl_bus_tx,
  input wire logic [CCSR_CHANNELS-1:0] ctrl_bus_rx,
  input wire logic ctrl_rstn,
  input wire logic [CCSR_CHANNELS-1:0] bus_rx_pin,
  input wire ccsr_req_type [CCSR_CHANNELS-1:0] irq_req,
  input wire logic dma_trigger_33,
  input wire logic combined_wake_irq,
  input wire logic standby_wake_req,
  input wire logic [CCSR_CHANNELS-1:0] bus_tx_pin,
  input wire logic [CCSR_CAPTURE_INPUTS-1:0] timestamp_pulse_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic any_wake;
  logic [1:0] settle_r;
  logic settled;
  assign any_wake = |(ctrl_req & 24'h111111);
  // Internal reset lets go two edges after rstn, and the receive path needs its history refilled
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      settle_r <= 2'h0;
    else if (settle_r != 2'h3)
      settle_r <= settle_r + 2'h1;
  end
  assign settled = (settle_r == 2'h3);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn || !settled);
  sequence s_req_cause; standby_mode && ctrl_req != '0; endsequence
  sequence s_bus_cause; standby_mode && !(&ctrl_bus_tx); endsequence
  property p_dma; dma_trigger_33 == $past(ctrl_req[5].tx_done); endproperty
  a_dma: assert property (p_dma) else $error("dma trigger mismatch");
  property p_req; irq_req == $past(ctrl_req); endproperty
  a_req: assert property (p_req) else $error("request copy mismatch");
  property p_comb; combined_wake_irq == $past(any_wake); endproperty
  a_comb: assert property (p_comb) else $error("combined wake mismatch");
  property p_sby; s_req_cause |=> standby_wake_req; endproperty
  a_sby: assert property (p_sby) else $error("request wake missing");
  property p_rst; system_reset_src || deep_stop_wake_reset |-> !ctrl_rstn; endproperty
  a_rst: assert property (p_rst) else $error("controller reset missing");
  property p_bus_wake; s_bus_cause |=> standby_wake_req; endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus wake missing");
  property p_ts; timestamp_pulse_out == {$past(ctrl_timestamp), 4'h0, $past(ctrl_timestamp)}; endproperty
  a_ts: assert property (p_ts) else $error("time stamp routing mismatch");
  property p_own; !bus_tx_pin[0] |-> !$past(ctrl_bus_tx[0]); endproperty
  a_own: assert property (p_own) else $error("pin0 dominant without cause");
  property p_rx0; ctrl_bus_rx[0] == $past(bus_rx_pin[0], 2) || ctrl_bus_rx[0] == $past(bus_rx_pin[1], 2); endproperty
  a_rx0: assert property (p_rx0) else $error("receive 0 from no pin");
  property p_merge; !$past(ctrl_bus_tx[0]) && bus_tx_pin[0] |-> !bus_tx_pin[1]; endproperty
  a_merge: assert property (p_merge) else $error("shared transmit lost");
endmodule

// ==== sim/ccsr_transceiver_model.sv ====
// Purpose: Bus pins seen through transceivers and remote nodes
// Assumes: Wired-AND bus, recessive 1 by pull-up
// Notes: Each pin echoes its own transmit; remote nodes may pull it dominant
module ccsr_transceiver_model
  import ccsr_pkg::*;
(
  input wire logic [CCSR_CHANNELS-1:0] bus_tx_pin,
  input wire logic [CCSR_CHANNELS-1:0] remote_dominant,
  output logic [CCSR_CHANNELS-1:0] bus_rx_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  assign bus_rx_pin = bus_tx_pin & ~remote_dominant;
endmodule

// ==== sim/ccsr_top_test.sv ====
// Purpose: Self-checking bench for ccsr_top
// Assumes: 40 MHz clock, bench acts as AXI4-Lite master
// Notes: Fixed waits only where pin latencies are fixed
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module ccsr_top_test
  import ccsr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [23:0] req; logic [5:0] ts; logic dma; logic wake; logic [15:0] tsx;} ccsr_row_type;
  ccsr_row_type rows [5] = '{'{24'h200000, 6'h01, 1'b1, 1'b0, 16'h0401}, '{24'h000001, 6'h20, 1'b0, 1'b1, 16'h8020},
    '{24'h800000, 6'h00, 1'b0, 1'b0, 16'h0000}, '{24'h444444, 6'h3f, 1'b0, 1'b0, 16'hfc3f},
    '{24'h000010, 6'h02, 1'b0, 1'b1, 16'h0802}};
  logic clk_sys = '0, rstn = '0, system_reset_src = '0, deep_stop_wake_reset = '0, standby_mode = '0;
  logic deep_stop_mode = '0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd_data;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ctrl_rstn;
  logic dma_trigger_33, combined_wake_irq, standby_wake_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  ccsr_req_type [CCSR_CHANNELS-1:0] ctrl_req = '0, irq_req;
  logic [CCSR_CHANNELS-1:0] ctrl_timestamp = '0, ctrl_bus_tx = '1, remote_dominant = '0;
  logic [CCSR_CHANNELS-1:0] ctrl_bus_rx, bus_rx_pin, bus_tx_pin;
  logic [CCSR_CAPTURE_INPUTS-1:0] timestamp_pulse_out;
  int errors = 0, comparisons = 0;
  ccsr_top ccsr_top_inst (.clk_sys, .rstn, .system_reset_src, .deep_stop_wake_reset, .deep_stop_mode,
    .standby_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl_req, .ctrl_timestamp,
    .ctrl_bus_tx, .ctrl_bus_rx, .ctrl_rstn, .bus_rx_pin, .irq_req, .dma_trigger_33, .combined_wake_irq,
    .standby_wake_req, .bus_tx_pin, .timestamp_pulse_out, .irq);
  ccsr_transceiver_model ccsr_transceiver_model_inst (.bus_tx_pin, .remote_dominant, .bus_rx_pin);
  always #12.5 clk_sys = ~clk_sys;
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100)
    begin
      errors++;
      $display("ERROR %0t write timed out", $time);
      stop_test();
    end
    `CHK(s_axi_bresp, CCSR_RESP_OKAY)
  endtask
  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 100);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100)
    begin
      errors++;
      $display("ERROR %0t read timed out", $time);
      stop_test();
    end
  endtask
  // Pin checks wait 4 edges: 1 for transmit, 2 for the receive synchroniser, 1 spare
  task automatic pins(input logic [5:0] tx, input logic [5:0] rem);
    @(posedge clk_sys);
    ctrl_bus_tx <= tx;
    remote_dominant <= rem;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      ctrl_req <= rows[i].req;
      ctrl_timestamp <= rows[i].ts;
      @(posedge clk_sys);
      #1;
      `CHK(irq_req, rows[i].req)
      `CHK(dma_trigger_33, rows[i].dma)
      `CHK(combined_wake_irq, rows[i].wake)
      `CHK(timestamp_pulse_out, rows[i].tsx)
    end
    @(posedge clk_sys);
    ctrl_req <= '0;
    ctrl_timestamp <= '0;
    rd(CCSR_ROUTE_ADDR);
    `CHK(rd_data, 32'h00000000)
    pins(6'h3e, 6'h00);
    `CHK({bus_tx_pin, ctrl_bus_rx}, 12'hfbe)
    pins(6'h3f, 6'h00);
    // Route only changes with every transmit recessive
    wr(CCSR_ROUTE_ADDR, 32'h00000001);
    rd(CCSR_ROUTE_ADDR);
    `CHK(rd_data, 32'h00000001)
    pins(6'h3e, 6'h00);
    `CHK({bus_tx_pin, ctrl_bus_rx}, 12'hf7c)
    pins(6'h3f, 6'h01);
    `CHK(ctrl_bus_rx[1:0], 2'h3)
    pins(6'h3f, 6'h00);
    rd(32'hff772014);
    `CHK({rd_resp, rd_data}, {CCSR_RESP_DECERR, 32'h00000000})
    for (int k = 1; k < 3; k++)
    begin
      wr(CCSR_ROUTE_ADDR, 32'h00000001);
      {deep_stop_wake_reset, system_reset_src} <= k[1:0];
      @(posedge clk_sys);
      #1;
      `CHK(ctrl_rstn, 1'b0)
      @(posedge clk_sys);
      {deep_stop_wake_reset, system_reset_src} <= 2'h0;
      rd(CCSR_ROUTE_ADDR);
      `CHK(rd_data, 32'h00000000)
      `CHK(ctrl_rstn, 1'b1)
    end
    // Lane 0 strobe low: the byte wide register must ignore the write
    s_axi_wstrb <= 4'h0;
    wr(CCSR_ROUTE_ADDR, 32'h00000001);
    s_axi_wstrb <= 4'h1;
    rd(CCSR_ROUTE_ADDR);
    `CHK(rd_data, 32'h00000000)
    @(posedge clk_sys);
    standby_mode <= 1'b1;
    ctrl_bus_tx <= 6'h37;
    @(posedge clk_sys);
    ctrl_bus_tx <= '1;
    ctrl_req <= 24'h000400;
    #1;
    `CHK(standby_wake_req, 1'b1)
    @(posedge clk_sys);
    ctrl_req <= '0;
    standby_mode <= 1'b0;
    #1;
    `CHK(standby_wake_req, 1'b1)
    // Idle edges first so the earlier transmit echo has left the receive synchroniser
    repeat (3) @(posedge clk_sys);
    deep_stop_mode <= 1'b1;
    remote_dominant <= 6'h04;
    @(posedge clk_sys);
    #1;
    `CHK(standby_wake_req, 1'b0)
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(standby_wake_req, 1'b1)
    @(posedge clk_sys);
    deep_stop_mode <= 1'b0;
    remote_dominant <= '0;
    repeat (4) @(posedge clk_sys);
    wr(CCSR_STATUS_ADDR, 32'h0000007f);
    wr(CCSR_MASK_ADDR, 32'h00000001);
    ctrl_req <= 24'h000001;
    @(posedge clk_sys);
    ctrl_req <= 24'h000010;
    @(posedge clk_sys);
    ctrl_req <= '0;
    #1;
    `CHK(irq, 1'b1)
    rd(CCSR_STATUS_ADDR);
    `CHK(rd_data, 32'h00000003)
    wr(CCSR_STATUS_ADDR, 32'h00000001);
    #1;
    `CHK(irq, 1'b0)
    // A wake event in the clearing cycle must keep its status bit
    @(posedge clk_sys);
    ctrl_req <= 24'h000001;
    wr(CCSR_STATUS_ADDR, 32'h00000001);
    ctrl_req <= '0;
    rd(CCSR_STATUS_ADDR);
    `CHK(rd_data, 32'h00000003)
    stop_test();
  end
endmodule
bind ccsr_top ccsr_top_properties ccsr_top_properties_inst (.clk_sys, .rstn, .system_reset_src,
  .deep_stop_wake_reset, .standby_mode,
  .ctrl_req, .ctrl_timestamp, .ctrl_bus_tx, .ctrl_bus_rx, .ctrl_rstn, .bus_rx_pin, .irq_req, .dma_trigger_33,
  .combined_wake_irq, .standby_wake_req, .bus_tx_pin, .timestamp_pulse_out);
